// ---- sdw_pkg.sv ----
/*
  shared constants and types for the sdram wait-cycle timing controller:
  register offsets, field positions, reset values and command codes.
  assumes a single 40 MHz core clock; all waits are counted in its cycles.
*/
package sdw_pkg;

  // core clock, for reference; waits are programmed directly in cycles
  localparam int CLK_PERIOD_NS = 25;

  // register map, byte addresses on the AHB-Lite port
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_WAIT_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT_OFF = 8'h04;

  // wait-control register layout
  localparam int PRE_WAIT_LSB = 13;
  localparam int PRE_WAIT_MSB = 14;
  localparam int ACT_WAIT_LSB = 10;
  localparam int ACT_WAIT_MSB = 11;
  localparam int WAIT_W = 2;
  localparam logic [WAIT_W-1:0] PRE_WAIT_RST = 2'h0;
  localparam logic [WAIT_W-1:0] ACT_WAIT_RST = 2'h1;
  localparam logic [31:0] WAIT_REG_MASK = 32'h0000_6C00;
  localparam logic [31:0] WAIT_REG_RST = 32'h0000_0400;

  // status register layout
  localparam int STAT_PRE_LSB = 0;
  localparam int STAT_ACT_LSB = 4;
  localparam int STAT_BUSY_BIT = 8;

  // banks
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;

  // helper gap counters used only by checks
  localparam int GAP_W = 3;
  localparam logic [GAP_W-1:0] GAP_MAX = 3'h7;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_BANK_OPEN = 3'h1,
    CMD_COLUMN_RD = 3'h2,
    CMD_COLUMN_WR = 3'h3,
    CMD_BANK_CLOSE = 3'h4,
    CMD_ALL_BANK_CLOSE = 3'h5,
    CMD_AUTO_REFRESH = 3'h6,
    CMD_SELF_REFRESH = 3'h7
  } sdw_cmd_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_ACK = 1'b1
  } sdw_state_t;

endpackage

// ---- sdw_wait_cnt.sv ----
/*
  one wait down-counter: loads a programmed wait and counts it off.
  assumes load is a single-cycle strobe from the command issue logic.
*/
`timescale 1ns/1ps
module sdw_wait_cnt (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [sdw_pkg::WAIT_W-1:0] load_val,
  output logic cnt_zero
);
  import sdw_pkg::*;

  logic [WAIT_W-1:0] cnt;
  logic [WAIT_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = load_val;
    end else if (cnt != 2'h0) begin
      // one bus clock per step, never faster [R10]
      next_cnt = cnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= 2'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign cnt_zero = (cnt == 2'h0);

  chk_count_down: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
    (!load && cnt != 2'h0) |=> (cnt == $past(cnt) - 2'h1))
    else $error("wait counter skipped a step");

endmodule

// ---- sdw_ahb_regs.sv ----
/*
  AHB-Lite slave holding the wait-control and status registers.
  assumes a single master, word-only single transfers, zero wait states.
*/
`timescale 1ns/1ps
module sdw_ahb_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] stat_in,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [sdw_pkg::WAIT_W-1:0] pre_wait,
  output logic [sdw_pkg::WAIT_W-1:0] act_wait
);
  import sdw_pkg::*;

  logic addr_ok;
  logic wr_pend;
  logic next_wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0] wait_reg;
  logic [31:0] next_wait_reg;
  logic [31:0] next_hrdata;

  // hsize is not decoded: only whole-word transfers are used on this port
  assign addr_ok = hsel && htrans[1] && hready;

  always_comb begin
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr[ADDR_W-1:0] : wr_addr;
    next_wait_reg = wait_reg;
    if (wr_pend && wr_addr == REG_WAIT_OFF) begin
      // reserved bits are dropped on write so they always read zero [R1] [R7]
      next_wait_reg = hwdata & WAIT_REG_MASK;
    end
    next_hrdata = hrdata;
    if (addr_ok && !hwrite) begin
      // read right after a write sees the new value through next_wait_reg
      unique case (haddr[ADDR_W-1:0])
        REG_WAIT_OFF: next_hrdata = next_wait_reg;
        REG_STAT_OFF: next_hrdata = stat_in;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      wait_reg <= WAIT_REG_RST; // [R2] [R9]
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      wait_reg <= next_wait_reg;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign pre_wait = wait_reg[PRE_WAIT_MSB:PRE_WAIT_LSB];
  assign act_wait = wait_reg[ACT_WAIT_MSB:ACT_WAIT_LSB];

  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b) // [R1] [R7]
    (hrdata[31:15] == 17'h0_0000) && (hrdata[12] == 1'b0))
    else $error("reserved read bits not zero");

  chk_prewait_reset: assert property (@(posedge clk) disable iff (!rst_b) // [R2]
    $rose(rst_b) |-> (pre_wait == PRE_WAIT_RST))
    else $error("precharge wait field not reset to zero");

  chk_actwait_reset: assert property (@(posedge clk) disable iff (!rst_b) // [R9]
    $rose(rst_b) |-> (act_wait == ACT_WAIT_RST))
    else $error("activate wait field not reset to one");

  chk_write_lands: assert property (@(posedge clk) disable iff (!rst_b) // [R2] [R8]
    (wr_pend && wr_addr == REG_WAIT_OFF) |=>
      (pre_wait == $past(hwdata[PRE_WAIT_MSB:PRE_WAIT_LSB])) &&
      (act_wait == $past(hwdata[ACT_WAIT_MSB:ACT_WAIT_LSB])))
    else $error("wait fields did not take the written value");

endmodule

// ---- sdw_ctrl.sv ----
/*
  sdram wait-cycle timing controller for one chip-select area: holds back
  dependent commands until the programmed precharge and activate waits pass.
  assumes the command sequencer holds a request until it sees CMD_ACK,
  and an AHB-Lite master with one slave on the register port.
*/
`timescale 1ns/1ps
// What this block does
// [R1] bits 31..15 of the wait-control register read zero; writes there ignored.
// [R2] precharge wait field, bits 14:13, gives 0..3 wait cycles; resets to zero.
// [R3] after auto-precharge starts, activate to that bank waits the precharge wait.
// [R4] after bank or all-bank close, activate to that bank waits the precharge wait.
// [R5] all-bank close to auto-refresh waits at least the precharge wait.
// [R6] all-bank close to self-refresh entry waits at least the precharge wait.
// [R7] bit 12 is reserved, reads zero, writes ignored.
// [R8] activate-to-column field at bits 11:10 sets activate-to-read/write wait; 00 none.
// [R9] activate-to-column field is bits 11:10, resets to 01, codes give 1..3.
// [R10] waits count bus clocks from the issuing command; more allowed, never fewer.
module sdw_ctrl (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CMD_REQ,
  input wire sdw_pkg::sdw_cmd_t CMD_CODE,
  input wire logic [sdw_pkg::BANK_W-1:0] CMD_BANK,
  input wire logic CMD_AUTO_PRE,
  output logic CMD_ACK,
  output sdw_pkg::sdw_cmd_t SD_CMD,
  output logic [sdw_pkg::BANK_W-1:0] SD_BANK,
  output logic SD_AUTO_PRE
);
  import sdw_pkg::*;

  logic [WAIT_W-1:0] pre_wait;
  logic [WAIT_W-1:0] act_wait;
  logic [31:0] stat_word;
  logic [NUM_BANKS-1:0] pre_zero;
  logic [NUM_BANKS-1:0] act_zero;
  logic [NUM_BANKS-1:0] pre_load;
  logic [NUM_BANKS-1:0] act_load;
  logic [NUM_BANKS-1:0] bank_hit;
  logic is_column;
  logic allowed;
  logic grant;

  sdw_state_t state;
  sdw_state_t next_state;
  logic next_ack;
  sdw_cmd_t next_sd_cmd;
  logic [BANK_W-1:0] next_sd_bank;
  logic next_sd_auto_pre;

  // register port
  sdw_ahb_regs u_regs (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .stat_in(stat_word),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .pre_wait(pre_wait),
    .act_wait(act_wait)
  );

  // status shows which banks are still inside a wait window
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_PRE_LSB +: NUM_BANKS] = ~pre_zero;
    stat_word[STAT_ACT_LSB +: NUM_BANKS] = ~act_zero;
    stat_word[STAT_BUSY_BIT] = (state == ST_ACK);
  end

  // command admission
  always_comb begin
    bank_hit = 4'h0;
    bank_hit[CMD_BANK] = 1'b1;
    is_column = (CMD_CODE == CMD_COLUMN_RD) || (CMD_CODE == CMD_COLUMN_WR);
    allowed = 1'b1;
    unique case (CMD_CODE)
      CMD_NOP: allowed = 1'b1;
      CMD_BANK_OPEN: allowed = pre_zero[CMD_BANK]; // [R3] [R4]
      CMD_COLUMN_RD: allowed = act_zero[CMD_BANK]; // [R8] [R9]
      CMD_COLUMN_WR: allowed = act_zero[CMD_BANK]; // [R8] [R9]
      CMD_BANK_CLOSE: allowed = 1'b1;
      CMD_ALL_BANK_CLOSE: allowed = 1'b1;
      // refresh waits for every bank, which also covers the all-bank close
      CMD_AUTO_REFRESH: allowed = &pre_zero; // [R5]
      CMD_SELF_REFRESH: allowed = &pre_zero; // [R6]
    endcase
    // one issue per handshake: the held request must not be taken twice
    grant = CMD_REQ && allowed && (state == ST_IDLE);
  end

  // per-bank wait windows
  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      // auto-precharge is taken as starting at the column command itself;
      // a burst that precharges later only lengthens the real gap [R3] [R10]
      assign pre_load[b] = grant && (
        (CMD_CODE == CMD_BANK_CLOSE && bank_hit[b]) ||
        (CMD_CODE == CMD_ALL_BANK_CLOSE) ||
        (is_column && CMD_AUTO_PRE && bank_hit[b])); // [R4] [R5] [R6]
      assign act_load[b] = grant && (CMD_CODE == CMD_BANK_OPEN) && bank_hit[b]; // [R8]

      sdw_wait_cnt u_pre (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .load(pre_load[b]),
        .load_val(pre_wait),
        .cnt_zero(pre_zero[b])
      );

      sdw_wait_cnt u_act (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .load(act_load[b]),
        .load_val(act_wait),
        .cnt_zero(act_zero[b])
      );

      // cycles since the last closing or opening issue, checks only
      logic [GAP_W-1:0] gap_pre;
      logic [GAP_W-1:0] gap_act;
      logic [GAP_W-1:0] next_gap_pre;
      logic [GAP_W-1:0] next_gap_act;

      // both saturate, so a long idle spell never wraps into a false short gap
      always_comb begin
        next_gap_pre = gap_pre;
        next_gap_act = gap_act;
        if (pre_load[b]) begin
          next_gap_pre = 3'h0;
        end else if (gap_pre != GAP_MAX) begin
          next_gap_pre = gap_pre + 3'h1;
        end
        if (act_load[b]) begin
          next_gap_act = 3'h0;
        end else if (gap_act != GAP_MAX) begin
          next_gap_act = gap_act + 3'h1;
        end
      end

      always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
          gap_pre <= GAP_MAX;
          gap_act <= GAP_MAX;
        end else begin
          gap_pre <= next_gap_pre;
          gap_act <= next_gap_act;
        end
      end

      chk_open_after_close: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R3] [R4] [R10]
        (SD_CMD == CMD_BANK_OPEN && SD_BANK == b) |-> (gap_pre > {1'b0, pre_wait}))
        else $error("bank opened before precharge wait elapsed");

      chk_column_after_open: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R8] [R9]
        ((SD_CMD == CMD_COLUMN_RD || SD_CMD == CMD_COLUMN_WR) && SD_BANK == b) |->
          (gap_act > {1'b0, act_wait}))
        else $error("column command before activate wait elapsed");

      chk_pre_window_open: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2] [R4]
        (pre_load[b] && pre_wait != 2'h0) |=> !pre_zero[b])
        else $error("precharge window did not open on load");

      // three quiet cycles drain the longest code; a stuck counter would
      // stall the sequencer for good
      chk_pre_window_close: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R2] [R10]
        (pre_load[b] ##1 (!pre_load[b])[*3]) |=> pre_zero[b])
        else $error("precharge window outlasted its longest code");

      chk_act_window_open: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R8] [R9]
        (act_load[b] && act_wait != 2'h0) |=> !act_zero[b])
        else $error("activate window did not open on load");

      chk_act_window_close: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R9] [R10]
        (act_load[b] ##1 (!act_load[b])[*3]) |=> act_zero[b])
        else $error("activate window outlasted its longest code");

      chk_col_held_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R8] [R9]
        (CMD_REQ && is_column && CMD_BANK == b && !act_zero[b]) |=> !CMD_ACK)
        else $error("column command accepted inside activate wait");

      chk_close_hit_only: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
        (grant && CMD_CODE == CMD_BANK_CLOSE && CMD_BANK != b) |-> !pre_load[b])
        else $error("closing one bank held off another");
    end
  endgenerate

  // handshake and command output
  always_comb begin
    next_state = grant ? ST_ACK : ST_IDLE;
    next_ack = grant;
    next_sd_cmd = grant ? CMD_CODE : CMD_NOP;
    next_sd_bank = grant ? CMD_BANK : SD_BANK;
    next_sd_auto_pre = grant && is_column && CMD_AUTO_PRE;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state <= ST_IDLE;
      CMD_ACK <= 1'b0;
      SD_CMD <= CMD_NOP;
      SD_BANK <= 2'h0;
      SD_AUTO_PRE <= 1'b0;
    end else begin
      state <= next_state;
      CMD_ACK <= next_ack;
      SD_CMD <= next_sd_cmd;
      SD_BANK <= next_sd_bank;
      SD_AUTO_PRE <= next_sd_auto_pre;
    end
  end

  // cycles since the last all-bank close, checks only
  // saturating like the per-bank gaps
  logic [GAP_W-1:0] gap_all_close;
  logic [GAP_W-1:0] next_gap_all_close;

  always_comb begin
    next_gap_all_close = gap_all_close;
    if (grant && CMD_CODE == CMD_ALL_BANK_CLOSE) begin
      next_gap_all_close = 3'h0;
    end else if (gap_all_close != GAP_MAX) begin
      next_gap_all_close = gap_all_close + 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      gap_all_close <= GAP_MAX;
    end else begin
      gap_all_close <= next_gap_all_close;
    end
  end

  chk_refresh_after_close: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5]
    (SD_CMD == CMD_AUTO_REFRESH) |-> (gap_all_close > {1'b0, pre_wait}))
    else $error("auto-refresh before precharge wait elapsed");

  chk_self_after_close: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R6]
    (SD_CMD == CMD_SELF_REFRESH) |-> (gap_all_close > {1'b0, pre_wait}))
    else $error("self-refresh entry before precharge wait elapsed");

  chk_ack_single: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R10]
    CMD_ACK |=> (!CMD_ACK && SD_CMD == CMD_NOP))
    else $error("command issued on two cycles in a row");

  chk_open_held_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R4]
    (CMD_REQ && CMD_CODE == CMD_BANK_OPEN && !pre_zero[CMD_BANK]) |=> !CMD_ACK)
    else $error("bank open accepted inside precharge wait");

  // command port hold-off and output checks
  chk_refresh_held_off: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5] [R6]
    (CMD_REQ && (CMD_CODE == CMD_AUTO_REFRESH || CMD_CODE == CMD_SELF_REFRESH) && !(&pre_zero))
      |=> !CMD_ACK)
    else $error("refresh accepted inside precharge wait");

  chk_all_close_loads: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R5] [R6]
    (grant && CMD_CODE == CMD_ALL_BANK_CLOSE && pre_wait != 2'h0) |=> (pre_zero == 4'h0))
    else $error("all-bank close left a bank without a window");

  chk_quiet_no_ack: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R10]
    !CMD_ACK |-> (SD_CMD == CMD_NOP && !SD_AUTO_PRE))
    else $error("command driven without a handshake");

  chk_auto_pre_column: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R3]
    SD_AUTO_PRE |-> (SD_CMD == CMD_COLUMN_RD || SD_CMD == CMD_COLUMN_WR))
    else $error("auto-precharge flagged on a non-column command");

  chk_issue_copies_req: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R10]
    grant |=> (CMD_ACK && SD_CMD == $past(CMD_CODE) && SD_BANK == $past(CMD_BANK)))
    else $error("issued command differs from the request taken");

  chk_nop_loads_none: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // [R10]
    (grant && CMD_CODE == CMD_NOP) |-> (pre_load == 4'h0 && act_load == 4'h0))
    else $error("nop opened a wait window");

  // no disable here, so the reset values themselves are seen
  chk_reset_quiet: assert property (@(posedge CORE_CLK) // [R10]
    !RST_B |=> (!CMD_ACK && SD_CMD == CMD_NOP && SD_BANK == 2'h0))
    else $error("command port not quiet after reset");

endmodule

// ---- sdw_sdram_model.sv ----
/*
  passive model of the external sdram devices behind the wait-cycle block.
  assumes the bench hands it the wait codes it has programmed into the block.
*/
`timescale 1ns/1ps
module sdw_sdram_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire sdw_pkg::sdw_cmd_t sd_cmd,
  input wire logic [sdw_pkg::BANK_W-1:0] sd_bank,
  input wire logic sd_auto_pre,
  input wire logic [sdw_pkg::WAIT_W-1:0] pre_wait,
  input wire logic [sdw_pkg::WAIT_W-1:0] act_wait,
  output int violations
);
  import sdw_pkg::*;
  // cycles since the last close, open or all-bank close, saturating at 8
  int since_close [NUM_BANKS];
  int since_open [NUM_BANKS];
  int since_all;
  always @(posedge clk) begin
    if (!rst_b) begin
      violations <= 0;
      since_all <= 8;
      for (int b = 0; b < NUM_BANKS; b++) begin
        since_close[b] <= 8;
        since_open[b] <= 8;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        since_close[b] <= (since_close[b] < 8) ? since_close[b] + 1 : 8;
        since_open[b] <= (since_open[b] < 8) ? since_open[b] + 1 : 8;
      end
      since_all <= (since_all < 8) ? since_all + 1 : 8;
      case (sd_cmd)
        CMD_BANK_OPEN: begin
          // a bank opened before its precharge completes would lose data
          if (since_close[sd_bank] <= pre_wait) begin
            violations <= violations + 1;
          end
          since_open[sd_bank] <= 1;
        end
        CMD_COLUMN_RD, CMD_COLUMN_WR: begin
          if (since_open[sd_bank] <= act_wait) begin
            violations <= violations + 1;
          end
          if (sd_auto_pre) begin
            since_close[sd_bank] <= 1;
          end
        end
        CMD_BANK_CLOSE: begin
          since_close[sd_bank] <= 1;
        end
        CMD_ALL_BANK_CLOSE: begin
          since_all <= 1;
          for (int b = 0; b < NUM_BANKS; b++) begin
            since_close[b] <= 1;
          end
        end
        CMD_AUTO_REFRESH, CMD_SELF_REFRESH: begin
          if (since_all <= pre_wait) begin
            violations <= violations + 1;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// ---- test_sdw_ctrl.sv ----
/*
  self-checking bench for the sdram wait-cycle block: register port over
  AHB-Lite, command gaps measured at the command port and by the sdram model.
  assumes one slave on the bus, so hready is the block's own hreadyout.
*/
`timescale 1ns/1ps
module test_sdw_ctrl;
  import sdw_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic cmd_req = 1'b0;
  sdw_cmd_t cmd_code = CMD_NOP;
  logic [BANK_W-1:0] cmd_bank = 2'h0;
  logic cmd_auto_pre = 1'b0;
  logic cmd_ack;
  sdw_cmd_t sd_cmd;
  logic [BANK_W-1:0] sd_bank;
  logic sd_auto_pre;
  logic [WAIT_W-1:0] pre_n = PRE_WAIT_RST;
  logic [WAIT_W-1:0] act_n = ACT_WAIT_RST;
  int violations;
  int cyc = 0;
  int errors = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  sdw_ctrl i_dut (.CORE_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CMD_REQ(cmd_req), .CMD_CODE(cmd_code), .CMD_BANK(cmd_bank),
    .CMD_AUTO_PRE(cmd_auto_pre), .CMD_ACK(cmd_ack), .SD_CMD(sd_cmd), .SD_BANK(sd_bank),
    .SD_AUTO_PRE(sd_auto_pre));

  sdw_sdram_model i_mem (.clk(clk), .rst_b(rst_b), .sd_cmd(sd_cmd), .sd_bank(sd_bank),
    .sd_auto_pre(sd_auto_pre), .pre_wait(pre_n), .act_wait(act_n), .violations(violations));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one single word transfer; no wait-state count assumed, a stuck bus is left to the watchdog
  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0000_00, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    rdata = hrdata;
    check({31'h0, hresp}, 32'h0000_0000);
  endtask

  task automatic wreg(input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, REG_WAIT_OFF, d, r);
    pre_n <= d[PRE_WAIT_MSB:PRE_WAIT_LSB];
    act_n <= d[ACT_WAIT_MSB:ACT_WAIT_LSB];
  endtask

  // holds the request until the ack is sampled; returns the cycle of issue
  task automatic issue(input sdw_cmd_t code, input logic [1:0] bank, input logic ap, output int at);
    @(posedge clk);
    cmd_req <= 1'b1;
    cmd_code <= code;
    cmd_bank <= bank;
    cmd_auto_pre <= ap;
    do begin
      @(posedge clk);
    end while (cmd_ack !== 1'b1);
    at = cyc;
    check({29'h0, sd_cmd}, {29'h0, code});
    check({30'h0, sd_bank}, {30'h0, bank});
    check({31'h0, sd_auto_pre}, {31'h0, ap});
    cmd_req <= 1'b0;
  endtask

  // more cycles than programmed are legal, fewer never
  task automatic gap(input int a, input int b, input int n);
    check({31'h0, (b - a) >= n + 1}, 32'h0000_0001);
  endtask

  task automatic test_reset;
    logic [31:0] r;
    int t;
    check({29'h0, sd_cmd}, {29'h0, CMD_NOP});
    ahb(1'b0, REG_WAIT_OFF, 32'h0000_0000, r);
    check(r, WAIT_REG_RST);
    ahb(1'b0, REG_STAT_OFF, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    ahb(1'b0, 8'h08, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    // a nop is taken at once and opens no window
    issue(CMD_NOP, 2'h2, 1'b0, t);
    ahb(1'b0, REG_STAT_OFF, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic test_reserved;
    logic [31:0] r;
    wreg(32'hFFFF_FFFF);
    ahb(1'b0, REG_WAIT_OFF, 32'h0000_0000, r);
    check(r, WAIT_REG_MASK);
    wreg(32'h0000_0000);
    ahb(1'b0, REG_WAIT_OFF, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    $display("test reserved done");
  endtask

  task automatic test_bank_gaps;
    int t [7];
    for (int n = 0; n < 4; n++) begin
      wreg({17'h0, n[1:0], 1'b0, n[1:0], 10'h0});
      issue(CMD_BANK_CLOSE, 2'h1, 1'b0, t[0]);
      issue(CMD_BANK_OPEN, 2'h1, 1'b0, t[1]);
      gap(t[0], t[1], n);
      issue(CMD_COLUMN_RD, 2'h1, 1'b0, t[2]);
      gap(t[1], t[2], n);
      issue(CMD_COLUMN_WR, 2'h1, 1'b1, t[3]);
      issue(CMD_BANK_OPEN, 2'h1, 1'b0, t[4]);
      gap(t[3], t[4], n);
      issue(CMD_ALL_BANK_CLOSE, 2'h0, 1'b0, t[5]);
      issue(CMD_BANK_OPEN, 2'h2, 1'b0, t[6]);
      gap(t[5], t[6], n);
    end
    $display("test bank gaps done");
  endtask

  task automatic test_refresh_gaps;
    int t [4];
    for (int n = 0; n < 4; n++) begin
      wreg({17'h0, n[1:0], 1'b0, 2'h1, 10'h0});
      issue(CMD_ALL_BANK_CLOSE, 2'h0, 1'b0, t[0]);
      issue(CMD_AUTO_REFRESH, 2'h0, 1'b0, t[1]);
      gap(t[0], t[1], n);
      issue(CMD_ALL_BANK_CLOSE, 2'h3, 1'b0, t[2]);
      issue(CMD_SELF_REFRESH, 2'h3, 1'b0, t[3]);
      gap(t[2], t[3], n);
    end
    $display("test refresh gaps done");
  endtask

  initial begin
    #(25 * 20000);
    errors++;
    test_done;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    test_reset;
    test_reserved;
    test_bank_gaps;
    test_refresh_gaps;
    repeat (2) @(posedge clk);
    check(violations, 32'h0000_0000);
    test_done;
  end
endmodule
